//--- rdhp_pkg_sync.sv
// Shared constants and types for the remote-terminal host port, plus the pin-input synchroniser.
`timescale 1ns/10ps
`default_nettype none

package rdhp_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_NS = 100;
  localparam int unsigned PHASE_NS = 500;
  localparam int unsigned PHASE_CYC = (PHASE_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned STROBE_NS = 300;
  localparam int unsigned STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned HS_TIMEOUT_NS = 15300;
  localparam int unsigned HS_CYC = HS_TIMEOUT_NS / CLK_NS;
  localparam int unsigned GOOD_PULSE_NS = 1000;
  localparam int unsigned GOOD_CYC = (GOOD_PULSE_NS + CLK_NS - 1) / CLK_NS;

  // ----------------------------------------------------------------
  // Widths and register map
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 14;
  localparam int unsigned DATA_W = 16;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_ADDR = 8'h08;
  localparam logic [7:0] OFF_WDATA = 8'h0c;
  localparam logic [7:0] OFF_RDATA = 8'h10;
  localparam logic [7:0] OFF_CMD = 8'h14;
  localparam logic [7:0] OFF_MSG = 8'h18;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h1c;
  localparam logic [7:0] OFF_IRQ_CLR = 8'h20;
  localparam logic [7:0] OFF_IRQ_EN = 8'h24;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam int unsigned CMD_START_BIT = 1 - 1;
  localparam int unsigned CMD_READ_BIT = 1;
  localparam int unsigned MSG_END_BIT = 0;
  localparam int unsigned MSG_ERR_BIT = 1;
  localparam logic CTRL_EN_RST = 1'b0;
  localparam logic [3:0] IRQ_EN_RST = 4'h0;
  localparam logic ACK_N_RST = 1'b1;
  localparam logic CFG_RST = 1'b0;

  typedef enum logic [1:0] {S_IDLE, S_REQ, S_XFER, S_REL} rdhp_state_t;

  typedef struct packed {
    logic hs_fail;
    logic bad_msg;
    logic good_msg;
    logic done;
  } rdhp_evt_t;

  typedef struct packed {
    logic act;
    logic wr;
    logic [7:0] off;
  } rdhp_aphase_t;
endpackage : rdhp_pkg

// Three-stage synchroniser; output follows once stages two and three agree
module rdhp_sync #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic i_clk,          // Clock
  input wire logic i_rst_n,        // Synchronised reset, active low
  input wire logic i_ce,           // Clock enable
  input wire logic [W-1:0] i_d,    // Asynchronous input
  output logic [W-1:0] o_q         // Filtered level
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1_reg <= RST;
      s2_reg <= RST;
      s3_reg <= RST;
      o_q <= RST;
    end else if (i_ce) begin
      s1_reg <= i_d;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      for (int i = 0; i < int'(W); i++) begin
        if (s2_reg[i] == s3_reg[i]) begin
          o_q[i] <= s3_reg[i];
        end
      end
    end
  end
endmodule : rdhp_sync

`default_nettype wire

//--- rdhp_top.sv
// Remote-terminal DMA host port: AHB-Lite registers, memory-transfer sequencer and pin drivers.
// How it works
// R1: Tristate select high makes address and control outputs three-state, not continuously driven.
// R2: In tristate mode, lines float unless acknowledge is low during our own access.
// R3: Width select low: one 16-bit transfer, byte-lane output held at 1.
// R4: Width select high: byte transfers, lane output 1 for upper, 0 lower.
// R5: Outside logic ties each lower data line to its upper partner.
// R6: Good-message flag pulses low only after software validates a finished message.
// R7: Simple outside logic may latch words, then copy them on good message.
// R8: Outside logic discards a message with any word error.
// R9: Byte mode sends the upper byte first, then the lower byte.
// R10: Tristate and width selects are taken only while no transfer runs.
//
// Decided for this implementation: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/10ps
`default_nettype none

module rdhp_top #(
  parameter int unsigned ADDR_W = rdhp_pkg::ADDR_W,
  parameter int unsigned DATA_W = rdhp_pkg::DATA_W,
  parameter int unsigned HS_CYC = rdhp_pkg::HS_CYC
) (
  input wire logic i_clk,                         // 10 MHz clock
  input wire logic i_nrst,                        // Async reset, active low
  input wire logic i_ce,                          // Clock enable
  input wire logic i_hsel,                        // AHB select
  input wire logic [31:0] i_haddr,                // AHB address
  input wire logic [1:0] i_htrans,                // AHB transfer type
  input wire logic i_hwrite,                      // AHB write
  input wire logic [2:0] i_hsize,                 // AHB size (word only)
  input wire logic [31:0] i_hwdata,               // AHB write data
  input wire logic i_hready,                      // AHB ready in
  output logic [31:0] o_hrdata,                   // AHB read data
  output logic o_hreadyout,                       // AHB ready out
  output logic o_hresp,                           // AHB response
  output logic o_irq,                             // Interrupt, active high
  input wire logic i_addr_tristate_select,        // Three-state mode pin
  input wire logic i_data_width_select,           // 0 word, 1 byte mode
  input wire logic i_transfer_acknowledge_n,      // Transfer grant, low
  output logic o_transfer_request_n,              // Transfer request, low
  output logic [ADDR_W-1:0] o_mem_addr,           // Memory address
  output logic o_mem_addr_oe,                     // Address enable
  output logic [DATA_W-1:0] o_data,               // Data out
  output logic [DATA_W-1:0] o_data_oe,            // Data enable per line
  input wire logic [DATA_W-1:0] i_data,           // Data in
  output logic o_mem_select_n,                    // Memory select, low
  output logic o_write_strobe_n,                  // Low on memory write
  output logic o_ctrl_oe,                         // Select/strobe enable
  output logic o_byte_lane_select,                // 1 upper, 0 lower byte
  output logic o_good_message_flag_n              // Good message, low
);
  localparam int unsigned HALF = DATA_W / 2;
  localparam logic [DATA_W-1:0] OE_HI = {{HALF{1'b1}}, {HALF{1'b0}}};
  localparam logic [DATA_W-1:0] OE_LO = {{HALF{1'b0}}, {HALF{1'b1}}};
  localparam logic [7:0] PH_LAST = 8'(rdhp_pkg::PHASE_CYC - 1);
  localparam logic [7:0] STB_LAST = 8'(rdhp_pkg::STROBE_CYC);
  localparam logic [15:0] HS_LAST = 16'(HS_CYC - 1);
  localparam logic [7:0] GOOD_LEN = 8'(rdhp_pkg::GOOD_CYC);

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction : hit

  // ----------------------------------------------------------------
  // Reset release and pin synchronisers
  // ----------------------------------------------------------------
  logic rst_a_reg;
  logic rst_n;
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_a_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_a_reg <= 1'b1;
      rst_n <= rst_a_reg;
    end
  end

  logic [2:0] pins_s;
  logic [DATA_W-1:0] data_s;
  rdhp_sync #(.W(3), .RST({rdhp_pkg::ACK_N_RST, rdhp_pkg::CFG_RST, rdhp_pkg::CFG_RST})) u_pin_sync (
    .i_clk(i_clk),
    .i_rst_n(rst_n),
    .i_ce(i_ce),
    .i_d({i_transfer_acknowledge_n, i_addr_tristate_select, i_data_width_select}),
    .o_q(pins_s)
  );
  rdhp_sync #(.W(DATA_W), .RST('0)) u_data_sync (
    .i_clk(i_clk),
    .i_rst_n(rst_n),
    .i_ce(i_ce),
    .i_d(i_data),
    .o_q(data_s)
  );
  wire logic ack_n_s = pins_s[2];

  // ----------------------------------------------------------------
  // AHB-Lite slave, zero wait states, always OKAY
  // ----------------------------------------------------------------
  rdhp_pkg::rdhp_aphase_t ap_reg;
  logic ctrl_en_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [DATA_W-1:0] wdata_reg;
  logic [DATA_W-1:0] rdata_reg;
  rdhp_pkg::rdhp_evt_t irq_stat_reg;
  rdhp_pkg::rdhp_evt_t irq_en_reg;
  rdhp_pkg::rdhp_evt_t evt;
  rdhp_pkg::rdhp_state_t state_reg;
  logic cfg_tri_reg;
  logic cfg_byte_reg;
  logic [7:0] gbr_cnt_reg;

  wire logic wr_go = ap_reg.act && ap_reg.wr;
  wire logic start = wr_go && hit(ap_reg.off, rdhp_pkg::OFF_CMD) && i_hwdata[rdhp_pkg::CMD_START_BIT];
  wire logic msg_end = wr_go && hit(ap_reg.off, rdhp_pkg::OFF_MSG) && i_hwdata[rdhp_pkg::MSG_END_BIT];
  wire logic irq_clr = wr_go && hit(ap_reg.off, rdhp_pkg::OFF_IRQ_CLR);

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (i_haddr[7:0])
      rdhp_pkg::OFF_CTRL: rd_mux[rdhp_pkg::CTRL_EN_BIT] = ctrl_en_reg;
      rdhp_pkg::OFF_STATUS: rd_mux[4:0] = {gbr_cnt_reg != 8'h00, ack_n_s, cfg_tri_reg, cfg_byte_reg,
                                          state_reg != rdhp_pkg::S_IDLE};
      rdhp_pkg::OFF_ADDR: rd_mux[ADDR_W-1:0] = addr_reg;
      rdhp_pkg::OFF_WDATA: rd_mux[DATA_W-1:0] = wdata_reg;
      rdhp_pkg::OFF_RDATA: rd_mux[DATA_W-1:0] = rdata_reg;
      rdhp_pkg::OFF_IRQ_STAT: rd_mux[3:0] = irq_stat_reg;
      rdhp_pkg::OFF_IRQ_EN: rd_mux[3:0] = irq_en_reg;
      default: rd_mux = 32'h0000_0000;
    endcase
    if (i_haddr[31:8] != 24'h00_0000) begin
      rd_mux = 32'h0000_0000;
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      ap_reg <= '0;
      o_hrdata <= 32'h0000_0000;
      o_hreadyout <= 1'b0;
      o_hresp <= 1'b0;
    end else if (i_ce) begin
      o_hreadyout <= 1'b1;
      if (i_hready) begin
        ap_reg.act <= i_hsel && i_htrans[1];
        ap_reg.wr <= i_hwrite;
        ap_reg.off <= (i_haddr[31:8] == 24'h00_0000) ? i_haddr[7:0] : 8'hff;
        if (i_hsel && i_htrans[1] && !i_hwrite) begin
          o_hrdata <= rd_mux;
        end
      end
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_en_reg <= rdhp_pkg::CTRL_EN_RST;
      addr_reg <= '0;
      wdata_reg <= '0;
      irq_en_reg <= rdhp_pkg::IRQ_EN_RST;
    end else if (i_ce && wr_go) begin
      if (hit(ap_reg.off, rdhp_pkg::OFF_CTRL)) begin
        ctrl_en_reg <= i_hwdata[rdhp_pkg::CTRL_EN_BIT];
      end
      if (hit(ap_reg.off, rdhp_pkg::OFF_ADDR)) begin
        addr_reg <= i_hwdata[ADDR_W-1:0];
      end
      if (hit(ap_reg.off, rdhp_pkg::OFF_WDATA)) begin
        wdata_reg <= i_hwdata[DATA_W-1:0];
      end
      if (hit(ap_reg.off, rdhp_pkg::OFF_IRQ_EN)) begin
        irq_en_reg <= i_hwdata[3:0];
      end
    end
  end

  // Set beats clear when both land in one cycle
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_reg <= '0;
      o_irq <= 1'b0;
    end else if (i_ce) begin
      irq_stat_reg <= (irq_stat_reg & ~(irq_clr ? i_hwdata[3:0] : 4'h0)) | evt;
      o_irq <= |(irq_stat_reg & irq_en_reg);
    end
  end

  // ----------------------------------------------------------------
  // Transfer sequencer
  // ----------------------------------------------------------------
  logic dir_read_reg;
  logic upper_reg;
  logic [7:0] cnt_reg;
  logic [15:0] tmo_reg;

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= rdhp_pkg::S_IDLE;
      dir_read_reg <= 1'b0;
      upper_reg <= 1'b1;
      cnt_reg <= 8'h00;
      tmo_reg <= 16'h0000;
      cfg_tri_reg <= rdhp_pkg::CFG_RST;
      cfg_byte_reg <= rdhp_pkg::CFG_RST;
      evt.done <= 1'b0;
      evt.hs_fail <= 1'b0;
      evt.good_msg <= 1'b0;
      evt.bad_msg <= 1'b0;
    end else if (i_ce) begin
      evt.done <= 1'b0;
      evt.hs_fail <= 1'b0;
      evt.good_msg <= msg_end && !i_hwdata[rdhp_pkg::MSG_ERR_BIT];
      evt.bad_msg <= msg_end && i_hwdata[rdhp_pkg::MSG_ERR_BIT];
      unique case (state_reg)
        rdhp_pkg::S_IDLE: begin
          cfg_tri_reg <= pins_s[1]; // [R10]
          cfg_byte_reg <= pins_s[0]; // [R10]
          tmo_reg <= 16'h0000;
          if (start && ctrl_en_reg) begin
            dir_read_reg <= i_hwdata[rdhp_pkg::CMD_READ_BIT];
            state_reg <= rdhp_pkg::S_REQ;
          end
        end
        rdhp_pkg::S_REQ: begin
          if (!ack_n_s) begin
            state_reg <= rdhp_pkg::S_XFER;
            cnt_reg <= 8'h00;
            upper_reg <= 1'b1; // [R9]
          end else if (tmo_reg == HS_LAST) begin
            evt.hs_fail <= 1'b1;
            state_reg <= rdhp_pkg::S_IDLE;
          end else begin
            tmo_reg <= tmo_reg + 16'h0001;
          end
        end
        rdhp_pkg::S_XFER: begin
          if (cnt_reg != PH_LAST) begin
            cnt_reg <= cnt_reg + 8'h01;
          end else if (cfg_byte_reg && upper_reg) begin
            upper_reg <= 1'b0; // [R4] [R9]
            cnt_reg <= 8'h00;
          end else begin
            evt.done <= 1'b1;
            tmo_reg <= 16'h0000;
            state_reg <= rdhp_pkg::S_REL;
          end
        end
        rdhp_pkg::S_REL: begin
          // A grant stuck low also counts as a failed handshake
          if (ack_n_s) begin
            state_reg <= rdhp_pkg::S_IDLE;
          end else if (tmo_reg == HS_LAST) begin
            evt.hs_fail <= 1'b1;
            state_reg <= rdhp_pkg::S_IDLE;
          end else begin
            tmo_reg <= tmo_reg + 16'h0001;
          end
        end
      endcase
    end
  end

  // Lane drops a cycle early, so lower-byte data clears the three-stage input by phase end
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= '0;
    end else if (i_ce && state_reg == rdhp_pkg::S_XFER && dir_read_reg && cnt_reg == PH_LAST) begin
      if (!cfg_byte_reg) begin
        rdata_reg <= data_s; // [R3]
      end else if (upper_reg) begin
        rdata_reg[DATA_W-1:HALF] <= data_s[DATA_W-1:HALF]; // [R4]
      end else begin
        rdata_reg[HALF-1:0] <= data_s[HALF-1:0]; // [R4]
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  wire logic in_xfer = (state_reg == rdhp_pkg::S_XFER) && !ack_n_s;
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_transfer_request_n <= 1'b1;
      o_mem_addr <= '0;
      o_mem_addr_oe <= 1'b0;
      o_ctrl_oe <= 1'b0;
      o_mem_select_n <= 1'b1;
      o_write_strobe_n <= 1'b1;
      o_byte_lane_select <= 1'b1;
      o_data <= '0;
      o_data_oe <= '0;
    end else if (i_ce) begin
      o_transfer_request_n <= !(state_reg == rdhp_pkg::S_REQ || state_reg == rdhp_pkg::S_XFER);
      o_mem_addr <= addr_reg;
      o_mem_addr_oe <= cfg_tri_reg ? in_xfer : 1'b1; // [R1] [R2]
      o_ctrl_oe <= cfg_tri_reg ? in_xfer : 1'b1; // [R1] [R2]
      o_mem_select_n <= !(in_xfer && cnt_reg >= 8'h01 && cnt_reg <= STB_LAST);
      o_write_strobe_n <= !(in_xfer && !dir_read_reg);
      o_byte_lane_select <= cfg_byte_reg ? (in_xfer ? (upper_reg && cnt_reg != PH_LAST) : 1'b1) : 1'b1; // [R3] [R4]
      o_data <= wdata_reg;
      // In byte mode halves are driven separately, so tied byte lanes never fight
      if (in_xfer && !dir_read_reg) begin
        o_data_oe <= !cfg_byte_reg ? '1 : (upper_reg ? OE_HI : OE_LO); // [R2] [R3] [R4]
      end else begin
        o_data_oe <= '0; // [R2]
      end
    end
  end

  // ----------------------------------------------------------------
  // Message validation and good-message flag
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      gbr_cnt_reg <= 8'h00;
      o_good_message_flag_n <= 1'b1;
    end else if (i_ce) begin
      if (msg_end && !i_hwdata[rdhp_pkg::MSG_ERR_BIT]) begin
        gbr_cnt_reg <= GOOD_LEN; // [R6]
      end else if (gbr_cnt_reg != 8'h00) begin
        gbr_cnt_reg <= gbr_cnt_reg - 8'h01;
      end
      o_good_message_flag_n <= !(gbr_cnt_reg != 8'h00); // [R6]
    end
  end

  wire logic unused_ok = &{1'b0, i_hsize};
endmodule : rdhp_top

`default_nettype wire

//--- rdhp_checker.sv
// Concurrent checks on the host port pins, bound to the top module.
`timescale 1ns/10ps
`default_nettype none

module rdhp_checker (
  input wire logic i_clk,                    // Clock
  input wire logic i_nrst,                   // Reset, low
  input wire logic i_hsel,                   // AHB select
  input wire logic [31:0] i_haddr,           // AHB address
  input wire logic [1:0] i_htrans,           // AHB type
  input wire logic i_hwrite,                 // AHB write
  input wire logic [31:0] i_hwdata,          // AHB data
  input wire logic i_hready,                 // AHB ready
  input wire logic i_addr_tristate_select,   // Tristate pin
  input wire logic i_data_width_select,      // Width pin
  input wire logic i_transfer_acknowledge_n, // Grant, low
  input wire logic o_mem_addr_oe,            // Address enable
  input wire logic [15:0] o_data_oe,         // Data enable
  input wire logic o_mem_select_n,           // Select, low
  input wire logic o_write_strobe_n,         // Write, low
  input wire logic o_ctrl_oe,                // Control enable
  input wire logic o_byte_lane_select,       // Lane
  input wire logic o_good_message_flag_n     // Good flag, low
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  // ----------------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------------
  logic [3:0] up_cnt;
  logic [3:0] low_cnt;
  logic msg_wr_q;
  logic [2:0] good_ago;
  // Pins reach the core through synchronisers, so wait before judging
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      up_cnt <= 4'h0;
      low_cnt <= 4'h0;
    end else begin
      up_cnt <= (up_cnt == 4'hf) ? up_cnt : up_cnt + 4'h1;
      low_cnt <= o_good_message_flag_n ? 4'h0 : low_cnt + 4'h1;
    end
  end
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      msg_wr_q <= 1'b0;
      good_ago <= 3'h7;
    end else begin
      if (i_hready) msg_wr_q <= i_hsel && i_htrans[1] && i_hwrite && i_haddr == {24'h0, rdhp_pkg::OFF_MSG};
      if (i_hready && msg_wr_q && i_hwdata[1:0] == 2'h1) good_ago <= 3'h0;
      else if (good_ago != 3'h7) good_ago <= good_ago + 3'h1;
    end
  end
  sequence lower_phase;
    !o_mem_select_n && !o_byte_lane_select;
  endsequence
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  lane_word_a: assert property (!i_data_width_select && !o_mem_select_n |-> o_byte_lane_select)
    else $error("lane select low in word mode");
  oe_word_a: assert property (!i_data_width_select && !o_mem_select_n && !o_write_strobe_n |-> o_data_oe == 16'hffff)
    else $error("word write not on all lines");
  oe_byte_a: assert property (i_data_width_select && !o_mem_select_n && !o_write_strobe_n
    |-> o_data_oe == (o_byte_lane_select ? 16'hff00 : 16'h00ff))
    else $error("byte lane and data enable disagree");
  upper_first_a: assert property (i_data_width_select && $rose(o_mem_select_n) && $past(o_byte_lane_select)
    |-> ##[1:8] lower_phase)
    else $error("lower byte missing after upper");
  two_state_a: assert property (up_cnt == 4'hf && !i_addr_tristate_select && !$past(i_addr_tristate_select, 8)
    |-> o_mem_addr_oe && o_ctrl_oe)
    else $error("two-state outputs not driven");
  float_idle_a: assert property ((i_addr_tristate_select && i_transfer_acknowledge_n) [*8]
    |-> !o_mem_addr_oe && !o_ctrl_oe && o_data_oe == 16'h0000)
    else $error("lines driven without grant");
  drive_access_a: assert property (i_addr_tristate_select && !o_mem_select_n |-> o_mem_addr_oe && o_ctrl_oe)
    else $error("access without enables");
  good_len_a: assert property ($rose(o_good_message_flag_n) |-> low_cnt == rdhp_pkg::GOOD_CYC)
    else $error("good flag pulse length wrong");
  good_cause_a: assert property ($fell(o_good_message_flag_n) |-> good_ago <= 3'h4)
    else $error("good flag without validation");
  word_wr_c: cover property (!i_data_width_select && !o_write_strobe_n && !o_mem_select_n);
  byte_rd_c: cover property ((i_data_width_select && o_write_strobe_n) and lower_phase);
  good_c: cover property ($fell(o_good_message_flag_n));
endmodule : rdhp_checker

bind rdhp_top rdhp_checker rdhp_checker_i (.i_clk, .i_nrst, .i_hsel, .i_haddr, .i_htrans, .i_hwrite,
  .i_hwdata, .i_hready, .i_addr_tristate_select, .i_data_width_select, .i_transfer_acknowledge_n,
  .o_mem_addr_oe, .o_data_oe, .o_mem_select_n, .o_write_strobe_n, .o_ctrl_oe, .o_byte_lane_select,
  .o_good_message_flag_n);
`default_nettype wire

//--- rdhp_mem_model.sv
// Behavioural host memory with grant logic and a two-stage receive latch.
`timescale 1ns/10ps
`default_nettype none

module rdhp_mem_model (
  input wire logic i_clk,          // Clock
  input wire logic i_req_n,        // Request, low
  input wire logic i_refuse,       // Never grant
  input wire logic [7:0] i_delay,  // Grant delay
  input wire logic i_width,        // Byte mode
  input wire logic i_sel_n,        // Select, low
  input wire logic i_wr_n,         // Write, low
  input wire logic i_lane,         // Lane
  input wire logic [15:0] i_dout,  // Device data
  input wire logic [15:0] i_doe,   // Device enables
  input wire logic i_good_n,       // Good flag
  output logic o_ack_n,            // Grant, low
  output logic [15:0] o_din,       // Resolved bus
  output logic [15:0] o_mem,       // First latch
  output logic [15:0] o_held,      // Second latch
  output logic o_first_lane        // Lane of first strobe
);
  logic [7:0] cnt = 8'h00;
  logic seen = 1'b0;
  logic [15:0] last = 16'h0000;
  logic [7:0] wbyte;
  logic [15:0] rdata;
  initial begin
    o_ack_n = 1'b1;
    o_mem = 16'h0000;
    o_held = 16'h0000;
    o_first_lane = 1'b0;
  end
  // Lanes are joined outside, so both carry the same byte
  assign wbyte = i_doe[15] ? i_dout[15:8] : i_dout[7:0];
  assign rdata = i_width ? {2{i_lane ? o_mem[15:8] : o_mem[7:0]}} : o_mem;
  // Undriven bus keeps flipping so a stale value never looks valid
  assign o_din = (|i_doe) ? (i_width ? {2{wbyte}} : i_dout) : (!o_ack_n && i_wr_n) ? rdata : ~last;
  always @(posedge i_clk) begin
    last <= o_din;
    if (i_req_n) begin
      cnt <= 8'h00;
      o_ack_n <= 1'b1;
      seen <= 1'b0;
    end else begin
      cnt <= (cnt == 8'hff) ? cnt : cnt + 8'h01;
      if (cnt >= i_delay && !i_refuse) o_ack_n <= 1'b0;
    end
    if (!i_sel_n && !i_wr_n) begin
      if (!seen) o_first_lane <= i_lane;
      seen <= 1'b1;
      if (!i_width) o_mem <= o_din;
      else if (i_lane) o_mem[15:8] <= wbyte;
      else o_mem[7:0] <= wbyte;
    end
  end
  // Only a confirmed message reaches the second latch
  always @(negedge i_good_n) o_held <= o_mem;
endmodule : rdhp_mem_model
`default_nettype wire

//--- tb_top.sv
// Self-checking bench for the host port: register tasks and transfer sequences.
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  logic i_clk = 1'b0, i_nrst = 1'b0, hwrite = 1'b0, tri_sel = 1'b0, wid_sel = 1'b0, refuse = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, v;
  logic [7:0] delay = 8'h02;
  logic [31:0] hrdata;
  logic hready, hresp, irq, req_n, ack_n, aoe, sel_n, wr_n, coe, lane, good_n;
  logic [13:0] maddr;
  logic [15:0] dout, doe, din, mem, held;
  logic first_lane;
  int n_errors = 0, comparisons = 0;
  always #50 i_clk = ~i_clk;

  rdhp_top #(.HS_CYC(20)) rdhp_top_i (.i_clk(i_clk), .i_nrst(i_nrst), .i_ce(1'b1), .i_hsel(1'b1),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
    .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp), .o_irq(irq),
    .i_addr_tristate_select(tri_sel), .i_data_width_select(wid_sel), .i_transfer_acknowledge_n(ack_n),
    .o_transfer_request_n(req_n), .o_mem_addr(maddr), .o_mem_addr_oe(aoe), .o_data(dout),
    .o_data_oe(doe), .i_data(din), .o_mem_select_n(sel_n), .o_write_strobe_n(wr_n), .o_ctrl_oe(coe),
    .o_byte_lane_select(lane), .o_good_message_flag_n(good_n));
  rdhp_mem_model rdhp_mem_model_i (.i_clk(i_clk), .i_req_n(req_n), .i_refuse(refuse), .i_delay(delay),
    .i_width(wid_sel), .i_sel_n(sel_n), .i_wr_n(wr_n), .i_lane(lane), .i_dout(dout), .i_doe(doe),
    .i_good_n(good_n), .o_ack_n(ack_n), .o_din(din), .o_mem(mem), .o_held(held),
    .o_first_lane(first_lane));

  task automatic end_of_test;
    $display("mismatches %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge i_clk);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    @(posedge i_clk);
    while (hready !== 1'b1) @(posedge i_clk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge i_clk);
    while (hready !== 1'b1) @(posedge i_clk);
    rd = hrdata;
  endtask : ahb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d, v);
  endtask : wr
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0, v);
    check(v, e);
  endtask : rdchk
  // Start a transfer, wait for its event bit, then clear it
  task automatic run(input logic [31:0] cmd, input int b);
    wr(rdhp_pkg::OFF_CMD, cmd);
    v = 32'h0;
    for (int k = 0; k < 300 && v[b] !== 1'b1; k++) ahb(1'b0, rdhp_pkg::OFF_IRQ_STAT, 32'h0, v);
    check({31'h0, v[b]}, 32'h1);
    check({31'h0, irq}, 32'h1);
    wr(rdhp_pkg::OFF_IRQ_CLR, 32'hf);
    rdchk(rdhp_pkg::OFF_IRQ_STAT, 32'h0);
    check({31'h0, irq}, 32'h0);
  endtask : run

  initial begin
    repeat (30000) @(posedge i_clk);
    n_errors++;
    end_of_test;
  end
  initial begin
    repeat (5) @(posedge i_clk);
    i_nrst <= 1'b1;
    repeat (8) @(posedge i_clk);
    rdchk(rdhp_pkg::OFF_CTRL, 32'h0);
    rdchk(rdhp_pkg::OFF_IRQ_EN, 32'h0);
    wr(8'h28, 32'hffffffff);
    rdchk(8'h28, 32'h0);
    wr(rdhp_pkg::OFF_CTRL, 32'h1);
    wr(rdhp_pkg::OFF_IRQ_EN, 32'hf);
    wr(rdhp_pkg::OFF_ADDR, 32'h0123);
    wr(rdhp_pkg::OFF_WDATA, 32'ha55a);
    run(32'h1, 0);
    check({16'h0, mem}, 32'ha55a);
    check({18'h0, maddr}, 32'h0123);
    check({31'h0, hresp}, 32'h0);
    wr(rdhp_pkg::OFF_WDATA, 32'h0);
    run(32'h3, 0);
    rdchk(rdhp_pkg::OFF_RDATA, 32'ha55a);
    // Mode pins change only between transfers
    wid_sel <= 1'b1;
    tri_sel <= 1'b1;
    delay <= 8'h0c;
    repeat (12) @(posedge i_clk);
    rdchk(rdhp_pkg::OFF_STATUS, 32'he);
    wr(rdhp_pkg::OFF_ADDR, 32'h3fff);
    wr(rdhp_pkg::OFF_WDATA, 32'h3cc3);
    run(32'h1, 0);
    check({16'h0, mem}, 32'h3cc3);
    check({31'h0, first_lane}, 32'h1);
    check({18'h0, maddr}, 32'h3fff);
    wr(rdhp_pkg::OFF_WDATA, 32'h0);
    run(32'h3, 0);
    rdchk(rdhp_pkg::OFF_RDATA, 32'h3cc3);
    wr(rdhp_pkg::OFF_MSG, 32'h1);
    repeat (3) @(posedge i_clk);
    check({31'h0, good_n}, 32'h0);
    check({16'h0, held}, 32'h3cc3);
    rdchk(rdhp_pkg::OFF_IRQ_STAT, 32'h2);
    wr(rdhp_pkg::OFF_IRQ_CLR, 32'hf);
    wr(rdhp_pkg::OFF_WDATA, 32'h0f0f);
    run(32'h1, 0);
    wr(rdhp_pkg::OFF_IRQ_EN, 32'hb);
    wr(rdhp_pkg::OFF_MSG, 32'h3);
    rdchk(rdhp_pkg::OFF_IRQ_STAT, 32'h4);
    check({31'h0, irq}, 32'h0);
    check({31'h0, good_n}, 32'h1);
    check({16'h0, held}, 32'h3cc3);
    wr(rdhp_pkg::OFF_IRQ_CLR, 32'hf);
    refuse <= 1'b1;
    run(32'h1, 3);
    end_of_test;
  end
endmodule : tb_top
`default_nettype wire
